// [rtl/cmo_decode.sv]
// instruction decode: effective address, select, op, level plan
// assumes instruction fields stable while op_valid is high
module cmo_decode (
	input wire logic [31:0] instr, // cache instruction word
	input wire logic [31:0] base_value, // base register contents
	input wire logic [2:0] coherency_attribute, // attr of the address
	output logic [31:0] ea, // effective address
	output logic [2:0] op, // operation code
	output logic [1:0] sel, // target cache
	output logic bcast, // broadcast to coherent caches
	output logic impl, // combination is implemented
	output logic [3:0] plan // levels to process
);
	// sign extend the offset field
	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	logic hit_op; // address-type removal op
	logic [3:0] tgt; // target bit

	// field extraction and address adder
	always_comb
	begin
		ea = base_value + sext16(instr[cmo_pkg::OFS_W-1:0]); // RULE20
		op = instr[cmo_pkg::OP_LSB+2:cmo_pkg::OP_LSB]; // RULE2
		sel = instr[cmo_pkg::SEL_LSB+1:cmo_pkg::SEL_LSB]; // RULE1
		hit_op = (op == cmo_pkg::OP_HIT_INV) || (op == cmo_pkg::OP_HIT_WBI);
		tgt = 4'h1 << sel;
	end

	// implemented combinations, everything else is a nop
	always_comb
	begin
		impl = |(tgt & cmo_pkg::LEVELS_PRESENT); // RULE21
		case (op)
			cmo_pkg::OP_IDX_INV, cmo_pkg::OP_LD_TAG,
			cmo_pkg::OP_ST_TAG: ;
			cmo_pkg::OP_IMPL: impl = impl & cmo_pkg::IMPL_OP_EN;
			cmo_pkg::OP_HIT_INV:
				impl = impl & ((sel == cmo_pkg::SEL_I) ||
					(sel == cmo_pkg::SEL_D) || cmo_pkg::HIT_ST_EN);
			cmo_pkg::OP_HIT_WBI:
				impl = impl & ((sel != cmo_pkg::SEL_I) ||
					cmo_pkg::FILL_EN);
			default: impl = 1'h0; // codes 6, 7 are unimplemented, a nop
		endcase
	end

	// one broadcast decision for all levels
	always_comb
	begin
		bcast = cmo_pkg::MP_COHERENT & hit_op &
			(sel != cmo_pkg::SEL_I) &
			cmo_pkg::COHERENT_CCA[coherency_attribute]; // RULE6 RULE7
	end

	// inner levels first for hit ops on outer caches
	always_comb
	begin
		plan = tgt;
		if (hit_op && (sel == cmo_pkg::SEL_S))
			plan = 4'ha; // RULE3
		else if (hit_op && (sel == cmo_pkg::SEL_T))
			plan = 4'he; // RULE3
		plan = plan & cmo_pkg::LEVELS_PRESENT;
	end
endmodule

// [rtl/cmo_holding.sv]
// tag and data holding registers of the coprocessor
// assumes pipeline writes and cache captures are single-cycle strobes
module cmo_holding (
	input wire logic clk_sys, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic sw_wr_en, // pipeline write strobe
	input wire logic [1:0] sw_wr_sel, // which holding register
	input wire logic [31:0] sw_wr_data, // write data
	input wire logic cap_en, // capture from tag read
	input wire logic [31:0] cap_tag_lo, // tag low from array
	input wire logic [31:0] cap_tag_hi, // tag high from array
	input wire logic [31:0] cap_dat_lo, // data low from array
	input wire logic [31:0] cap_dat_hi, // data high from array
	output logic [31:0] tag_low_holding_reg, // tag low
	output logic [31:0] tag_high_holding_reg, // tag high
	output logic [31:0] line_data_low_reg, // data low
	output logic [31:0] line_data_high_reg // data high
);
	// tag registers, capture wins over a write in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tag_low_holding_reg <= cmo_pkg::HOLD_RST;
			tag_high_holding_reg <= cmo_pkg::HOLD_RST;
		end
		else if (cap_en)
		begin
			tag_low_holding_reg <= cap_tag_lo; // RULE11
			tag_high_holding_reg <= cap_tag_hi; // RULE11
		end
		else if (sw_wr_en)
		begin
			if (sw_wr_sel == cmo_pkg::HSEL_TAG_LO)
				tag_low_holding_reg <= sw_wr_data;
			if (sw_wr_sel == cmo_pkg::HSEL_TAG_HI)
				tag_high_holding_reg <= sw_wr_data;
		end
	end

	// data registers, only if built
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_data_low_reg <= cmo_pkg::HOLD_RST;
			line_data_high_reg <= cmo_pkg::HOLD_RST;
		end
		else if (cmo_pkg::HAS_DATA_REGS && cap_en)
		begin
			line_data_low_reg <= cap_dat_lo; // RULE11 RULE12
			line_data_high_reg <= cap_dat_hi; // RULE11 RULE12
		end
		else if (cmo_pkg::HAS_DATA_REGS && sw_wr_en)
		begin
			if (sw_wr_sel == cmo_pkg::HSEL_DAT_LO)
				line_data_low_reg <= sw_wr_data;
			if (sw_wr_sel == cmo_pkg::HSEL_DAT_HI)
				line_data_high_reg <= sw_wr_data;
		end
	end
endmodule

// [rtl/cmo_pkg.sv]
// shared constants and types of the cache maintenance operation unit
// assumes one core clock and an external cache array command port
package cmo_pkg;
	// cache select field, instruction bits 17:16
	localparam logic [1:0] SEL_I = 2'h0; // primary instruction
	localparam logic [1:0] SEL_D = 2'h1; // primary data or unified
	localparam logic [1:0] SEL_T = 2'h2; // tertiary
	localparam logic [1:0] SEL_S = 2'h3; // secondary
	localparam int SEL_LSB = 16; // select field position
	localparam int OP_LSB = 18; // operation field position, bits 20:18
	localparam int OFS_W = 16; // offset field width
	// operation codes
	localparam logic [2:0] OP_IDX_INV = 3'h0; // index (writeback) inval
	localparam logic [2:0] OP_LD_TAG = 3'h1; // index load tag
	localparam logic [2:0] OP_ST_TAG = 3'h2; // index store tag
	localparam logic [2:0] OP_IMPL = 3'h3; // implementation specific
	localparam logic [2:0] OP_HIT_INV = 3'h4; // hit invalidate
	localparam logic [2:0] OP_HIT_WBI = 3'h5; // fill or hit wb inval
	// presence masks, one bit per select code
	localparam logic [3:0] LEVELS_PRESENT = 4'hf; // caches built
	localparam logic [3:0] WB_LEVELS = 4'he; // write-back levels
	localparam logic IMPL_OP_EN = 1'h1; // code 3 supported
	localparam logic FILL_EN = 1'h1; // instruction fill supported
	localparam logic HIT_ST_EN = 1'h1; // outer hit invalidate built
	localparam logic MP_COHERENT = 1'h1; // coherent multiprocessor
	localparam logic HAS_DATA_REGS = 1'h1; // data holding regs built
	localparam logic [7:0] COHERENT_CCA = 8'h30; // coherent attr codes
	// reset values
	localparam logic [31:0] HOLD_RST = 32'h0; // holding registers
	localparam logic [3:0] MASK_RST = 4'h0; // level plan
	// holding register select for pipeline writes
	localparam logic [1:0] HSEL_TAG_LO = 2'h0;
	localparam logic [1:0] HSEL_TAG_HI = 2'h1;
	localparam logic [1:0] HSEL_DAT_LO = 2'h2;
	localparam logic [1:0] HSEL_DAT_HI = 2'h3;
	// commands to the cache arrays
	typedef enum logic [2:0] {
		CMD_PROBE_IDX = 3'h0, // read state at index
		CMD_PROBE_HIT = 3'h1, // look up address
		CMD_WRITEBACK = 3'h2, // write block back to memory
		CMD_INVAL = 3'h3, // set block invalid
		CMD_READ_TAG = 3'h4, // read tag and data
		CMD_WRITE_TAG = 3'h5, // write tag from holding regs
		CMD_FILL = 3'h6, // fill line from memory
		CMD_IMPL = 3'h7 // implementation specific
	} cmd_kind_e;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ISSUE = 3'h1,
		ST_CMD = 3'h2,
		ST_RSP = 3'h3,
		ST_DONE = 3'h4
	} state_e;
	// step within one level
	typedef enum logic [1:0] {
		PH_PROBE = 2'h0,
		PH_WB = 2'h1,
		PH_ACT = 2'h2
	} phase_e;
endpackage

// [rtl/cmo_unit.sv]
// cache maintenance operation unit: sequences commands to cache levels
// assumes the cache arrays answer each taken command with one rsp_valid
//
// Functional notes
// (RULE1) decode cache select field into target cache
// (RULE2) operation code from bits 20..18, 3 optional
// (RULE3) hit ops on outer caches process inner first
// (RULE4) without ordering, software flushes inner first
// (RULE5) software syncs after writebacks before relying
// (RULE6) coherent attribute broadcasts hit ops, else not; hit ops on the instruction cache are never broadcast
// (RULE7) all affected levels share one broadcast choice
// (RULE8) index invalidate marks instruction block invalid
// (RULE9) index op writes back dirty, then invalidates
// (RULE10) write-through index op only invalidates
// (RULE11) load tag copies tag and data to holding
// (RULE12) data read is aligned, low bits ignored
// (RULE13) load tag never reports cache error
// (RULE14) store tag writes tag from holding registers
// (RULE15) store tag never reports cache error
// (RULE16) software loads holding regs before tag init
// (RULE17) hit invalidate clears block holding the address
// (RULE18) fill instruction cache line from address
// (RULE19) hit wb-invalidate writes dirty back, then invalidates
// (RULE20) effective address is base plus sign-extended offset
// (RULE21) unimplemented combination performs no operation
module cmo_unit (
	input wire logic clk_sys, // core clock, 200 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic op_valid, // cache instruction request
	input wire logic [31:0] instr, // instruction word
	input wire logic [31:0] base_value, // base register contents
	input wire logic [2:0] coherency_attribute, // attr of the address
	output logic op_ready, // unit idle, can take request
	output logic op_done, // operation finished pulse
	output logic op_error, // cache error with op_done
	input wire logic hold_wr_en, // pipeline write to holding reg
	input wire logic [1:0] hold_wr_sel, // holding register select
	input wire logic [31:0] hold_wr_data, // holding write data
	output logic [31:0] tag_low_holding_reg, // tag low holding
	output logic [31:0] tag_high_holding_reg, // tag high holding
	output logic [31:0] line_data_low_reg, // data low holding
	output logic [31:0] line_data_high_reg, // data high holding
	output logic cmd_valid, // command to cache arrays
	input wire logic cmd_ready, // arrays take command
	output logic [2:0] cmd_kind, // command kind
	output logic [1:0] cmd_level, // target cache level
	output logic [31:0] cmd_addr, // index or address
	output logic cmd_broadcast, // globalised operation
	input wire logic rsp_valid, // command finished pulse
	input wire logic rsp_hit, // probe: address present
	input wire logic rsp_line_valid, // probe: block valid
	input wire logic rsp_dirty, // probe: block dirty
	input wire logic rsp_err, // array or bus error
	input wire logic [31:0] rsp_tag_lo, // tag read low
	input wire logic [31:0] rsp_tag_hi, // tag read high
	input wire logic [31:0] rsp_dat_lo, // data read low
	input wire logic [31:0] rsp_dat_hi // data read high
);
	// pick next level in inner-to-outer order
	function automatic logic [1:0] first_level(input logic [3:0] m);
		if (m[cmo_pkg::SEL_I])
			first_level = cmo_pkg::SEL_I;
		else if (m[cmo_pkg::SEL_D])
			first_level = cmo_pkg::SEL_D;
		else if (m[cmo_pkg::SEL_S])
			first_level = cmo_pkg::SEL_S;
		else
			first_level = cmo_pkg::SEL_T;
	endfunction

	// first step for an op on a level
	function automatic cmo_pkg::phase_e first_phase(input logic [2:0] o,
		input logic [1:0] l);
		first_phase = cmo_pkg::PH_ACT;
		if (o == cmo_pkg::OP_IDX_INV && cmo_pkg::WB_LEVELS[l])
			first_phase = cmo_pkg::PH_PROBE; // RULE9
		if (o == cmo_pkg::OP_HIT_INV)
			first_phase = cmo_pkg::PH_PROBE; // RULE17
		if (o == cmo_pkg::OP_HIT_WBI && l != cmo_pkg::SEL_I)
			first_phase = cmo_pkg::PH_PROBE; // RULE19
	endfunction

	// final action command for an op on a level
	function automatic cmo_pkg::cmd_kind_e act_kind(input logic [2:0] o,
		input logic [1:0] l);
		case (o)
			cmo_pkg::OP_LD_TAG: act_kind = cmo_pkg::CMD_READ_TAG; // RULE11
			cmo_pkg::OP_ST_TAG: act_kind = cmo_pkg::CMD_WRITE_TAG; // RULE14
			cmo_pkg::OP_IMPL: act_kind = cmo_pkg::CMD_IMPL; // RULE2
			cmo_pkg::OP_HIT_WBI:
				act_kind = (l == cmo_pkg::SEL_I) ? cmo_pkg::CMD_FILL :
					cmo_pkg::CMD_INVAL; // RULE18
			default: act_kind = cmo_pkg::CMD_INVAL; // RULE8 RULE10
		endcase
	endfunction

	logic [31:0] dec_ea; // decoded effective address
	logic [2:0] dec_op; // decoded op
	logic [1:0] dec_sel; // decoded target
	logic dec_bcast; // decoded broadcast
	logic dec_impl; // decoded implemented
	logic [3:0] dec_plan; // decoded level plan
	cmo_pkg::state_e state_reg; // sequencer state
	cmo_pkg::phase_e phase_reg; // step within level
	logic [2:0] op_reg; // latched op
	logic [31:0] ea_reg; // latched effective address
	logic bcast_reg; // latched broadcast
	logic [3:0] mask_reg; // levels still to process
	logic [1:0] lvl_reg; // level in progress
	logic err_reg; // error seen during op
	logic cap_en; // tag read capture strobe
	logic tag_op; // op never reports errors
	logic cmd_take; // command handshake
	cmo_pkg::cmd_kind_e kind_now; // kind for this step
	logic [3:0] mask_left; // plan minus finished level

	// field decode and address adder
	cmo_decode u_decode (
		.instr(instr),
		.base_value(base_value),
		.coherency_attribute(coherency_attribute),
		.ea(dec_ea),
		.op(dec_op),
		.sel(dec_sel),
		.bcast(dec_bcast),
		.impl(dec_impl),
		.plan(dec_plan)
	);

	// tag and data holding registers
	cmo_holding u_holding (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sw_wr_en(hold_wr_en),
		.sw_wr_sel(hold_wr_sel),
		.sw_wr_data(hold_wr_data),
		.cap_en(cap_en),
		.cap_tag_lo(rsp_tag_lo),
		.cap_tag_hi(rsp_tag_hi),
		.cap_dat_lo(rsp_dat_lo),
		.cap_dat_hi(rsp_dat_hi),
		.tag_low_holding_reg(tag_low_holding_reg),
		.tag_high_holding_reg(tag_high_holding_reg),
		.line_data_low_reg(line_data_low_reg),
		.line_data_high_reg(line_data_high_reg)
	);

	// step decode helpers
	always_comb
	begin
		tag_op = (op_reg == cmo_pkg::OP_LD_TAG) ||
			(op_reg == cmo_pkg::OP_ST_TAG);
		cmd_take = cmd_valid && cmd_ready;
		mask_left = mask_reg & ~(4'h1 << lvl_reg);
		cap_en = (state_reg == cmo_pkg::ST_RSP) && rsp_valid &&
			(op_reg == cmo_pkg::OP_LD_TAG); // RULE11
		case (phase_reg)
			cmo_pkg::PH_PROBE:
				kind_now = (op_reg == cmo_pkg::OP_IDX_INV) ?
					cmo_pkg::CMD_PROBE_IDX : cmo_pkg::CMD_PROBE_HIT;
			cmo_pkg::PH_WB: kind_now = cmo_pkg::CMD_WRITEBACK;
			default: kind_now = act_kind(op_reg, lvl_reg);
		endcase
	end

	// sequencer, phase and level walk
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= cmo_pkg::ST_IDLE;
			phase_reg <= cmo_pkg::PH_ACT;
			mask_reg <= cmo_pkg::MASK_RST;
			lvl_reg <= cmo_pkg::SEL_I;
		end
		else
		begin
			case (state_reg)
				cmo_pkg::ST_IDLE:
					if (op_valid)
					begin
						mask_reg <= dec_plan;
						lvl_reg <= first_level(dec_plan); // RULE3
						phase_reg <= first_phase(dec_op,
							first_level(dec_plan));
						state_reg <= dec_impl ? cmo_pkg::ST_ISSUE :
							cmo_pkg::ST_DONE; // RULE21
					end
				cmo_pkg::ST_ISSUE: state_reg <= cmo_pkg::ST_CMD;
				cmo_pkg::ST_CMD:
					if (cmd_take)
						state_reg <= cmo_pkg::ST_RSP;
				cmo_pkg::ST_RSP:
					if (rsp_valid)
					begin
						state_reg <= cmo_pkg::ST_ISSUE;
						if (phase_reg == cmo_pkg::PH_PROBE &&
							rsp_line_valid && rsp_dirty &&
							cmo_pkg::WB_LEVELS[lvl_reg] &&
							(op_reg == cmo_pkg::OP_IDX_INV ||
							op_reg == cmo_pkg::OP_HIT_WBI && rsp_hit))
							phase_reg <= cmo_pkg::PH_WB; // RULE9 RULE19
						else if (phase_reg == cmo_pkg::PH_WB ||
							(phase_reg == cmo_pkg::PH_PROBE &&
							(op_reg == cmo_pkg::OP_IDX_INV ||
							rsp_hit)))
							phase_reg <= cmo_pkg::PH_ACT; // RULE17
						else if (mask_left != 4'h0)
						begin
							mask_reg <= mask_left; // RULE3
							lvl_reg <= first_level(mask_left);
							phase_reg <= first_phase(op_reg,
								first_level(mask_left));
						end
						else
						begin
							mask_reg <= mask_left;
							state_reg <= cmo_pkg::ST_DONE;
						end
					end
				cmo_pkg::ST_DONE: state_reg <= cmo_pkg::ST_IDLE;
				default: state_reg <= cmo_pkg::ST_IDLE;
			endcase
		end
	end

	// request latch taken in idle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_reg <= 3'h0;
			ea_reg <= 32'h0;
			bcast_reg <= 1'h0;
		end
		else if (state_reg == cmo_pkg::ST_IDLE && op_valid)
		begin
			op_reg <= dec_op; // RULE2
			ea_reg <= dec_ea; // RULE20
			bcast_reg <= dec_bcast; // RULE6 RULE7
		end
	end

	// command outputs, held until taken
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_valid <= 1'h0;
			cmd_kind <= 3'h0;
			cmd_level <= 2'h0;
			cmd_addr <= 32'h0;
			cmd_broadcast <= 1'h0;
		end
		else if (state_reg == cmo_pkg::ST_ISSUE)
		begin
			cmd_valid <= 1'h1;
			cmd_kind <= kind_now;
			cmd_level <= lvl_reg;
			cmd_addr <= ea_reg;
			cmd_broadcast <= bcast_reg; // RULE7
		end
		else if (cmd_take)
			cmd_valid <= 1'h0;
	end

	// error collection, tag ops never report
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			err_reg <= 1'h0;
		else if (state_reg == cmo_pkg::ST_IDLE)
			err_reg <= 1'h0;
		else if (state_reg == cmo_pkg::ST_RSP && rsp_valid && rsp_err &&
			!tag_op)
			err_reg <= 1'h1; // RULE13 RULE15
	end

	// requester handshake outputs
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_ready <= 1'h0;
			op_done <= 1'h0;
			op_error <= 1'h0;
		end
		else
		begin
			op_ready <= (state_reg == cmo_pkg::ST_IDLE) ? !op_valid :
				(state_reg == cmo_pkg::ST_DONE);
			op_done <= (state_reg == cmo_pkg::ST_DONE);
			op_error <= (state_reg == cmo_pkg::ST_DONE) && err_reg &&
				!tag_op; // RULE13 RULE15
		end
	end

	// checks of the sequencing
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic wb_seen; // last command taken was a writeback
	logic d_done; // primary data level answered a command this op
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_seen <= 1'h0;
			d_done <= 1'h0;
		end
		else
		begin
			if (state_reg == cmo_pkg::ST_IDLE)
				d_done <= 1'h0;
			else if (rsp_valid && lvl_reg == cmo_pkg::SEL_D)
				d_done <= 1'h1;
			if (cmd_take)
				wb_seen <= (cmd_kind == cmo_pkg::CMD_WRITEBACK);
		end
	end

	a_tag_no_error: assert property (op_done && tag_op |-> !op_error) // RULE13
		else $error("tag op reported a cache error");
	a_wb_then_inval: assert property ( // RULE9
		cmd_take && cmd_kind == cmo_pkg::CMD_WRITEBACK |->
		##[1:300] cmd_valid && cmd_kind == cmo_pkg::CMD_INVAL)
		else $error("writeback not followed by invalidate");
	a_wt_no_wb: assert property (cmd_valid && // RULE10
		cmd_kind == cmo_pkg::CMD_WRITEBACK |->
		cmo_pkg::WB_LEVELS[cmd_level])
		else $error("writeback on write-through level");
	a_inner_first: assert property (cmd_valid && // RULE3
		cmd_level == cmo_pkg::SEL_S && op_reg[2] &&
		cmo_pkg::LEVELS_PRESENT[cmo_pkg::SEL_D] |-> d_done)
		else $error("outer level before inner level");
	a_bcast_same: assert property ($rose(cmd_valid) && // RULE7
		$past(state_reg, 2) == cmo_pkg::ST_RSP |->
		cmd_broadcast == $past(cmd_broadcast))
		else $error("broadcast changed between levels");
	a_bcast_hit_only: assert property (cmd_valid && cmd_broadcast |-> // RULE6
		op_reg == cmo_pkg::OP_HIT_INV || op_reg == cmo_pkg::OP_HIT_WBI)
		else $error("broadcast on non-hit op");
	a_ea_sum: assert property (state_reg == cmo_pkg::ST_IDLE && // RULE20
		op_valid |=> ea_reg == $past(base_value) +
		{{16{$past(instr[15])}}, $past(instr[15:0])})
		else $error("effective address wrong");
	a_nop_unimpl: assert property (state_reg == cmo_pkg::ST_IDLE && // RULE21
		op_valid && !dec_impl |-> ##1 !cmd_valid ##1 op_done)
		else $error("unimplemented op not a nop");
	a_ld_capture: assert property (cap_en |=> // RULE11
		tag_low_holding_reg == $past(rsp_tag_lo))
		else $error("tag not captured");
	a_fill_icache: assert property (cmd_valid && // RULE18
		cmd_level == cmo_pkg::SEL_I && op_reg == cmo_pkg::OP_HIT_WBI |->
		cmd_kind == cmo_pkg::CMD_FILL)
		else $error("instruction fill kind wrong");
	c_wb_inval: cover property (cmd_take &&
		cmd_kind == cmo_pkg::CMD_INVAL && wb_seen);
	c_bcast: cover property (cmd_take && cmd_broadcast);
	c_three_levels: cover property (cmd_take && cmd_level ==
		cmo_pkg::SEL_T && d_done);
	c_tag_read: cover property (cap_en);
endmodule

// [tb/cache_array_model.sv]
// behavioural cache arrays answering the unit's command port
// assumes bench knobs give probe outcome, error and answer delay
module cache_array_model (
	input wire logic clk_sys, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic cmd_valid, // command offered
	input wire logic [31:0] cmd_addr, // index or address
	input wire logic k_hit, // probe finds the address
	input wire logic k_dirty, // probed block dirty
	input wire logic k_err, // array reports an error
	input wire logic [3:0] k_slow, // wait cycles before ready and answer
	output logic cmd_ready, // command taken
	output logic rsp_valid, // command finished pulse
	output logic rsp_hit, // address present
	output logic rsp_line_valid, // block valid
	output logic rsp_dirty, // block dirty
	output logic rsp_err, // error seen
	output logic [31:0] rsp_tag_lo, // tag low
	output logic [31:0] rsp_tag_hi, // tag high
	output logic [31:0] rsp_dat_lo, // data low
	output logic [31:0] rsp_dat_hi // data high
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pend; // command taken, answer owed
	logic [3:0] cnt; // delay counter
	logic [31:0] a; // address of the taken command
	// outside the answer cycle hit, dirty and err show inverted values, line valid is low, tag and data show other values
	assign rsp_hit = rsp_valid ? k_hit : ~k_hit;
	assign rsp_line_valid = rsp_valid;
	assign rsp_dirty = rsp_valid ? k_dirty : ~k_dirty;
	assign rsp_err = rsp_valid ? k_err : ~k_err;
	assign rsp_tag_lo = rsp_valid ? a ^ 32'ha5a50000 : a;
	assign rsp_tag_hi = rsp_valid ? ~a : a;
	assign rsp_dat_lo = rsp_valid ? a + 32'h1 : ~a;
	assign rsp_dat_hi = rsp_valid ? a + 32'h2 : ~a;
	// ready after k_slow cycles, answer k_slow cycles after take
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_ready <= 1'h0;
			rsp_valid <= 1'h0;
			pend <= 1'h0;
			cnt <= 4'h0;
			a <= 32'h0;
		end
		else
		begin
			rsp_valid <= 1'h0;
			if (cmd_valid && cmd_ready)
			begin
				cmd_ready <= 1'h0;
				pend <= 1'h1;
				cnt <= 4'h0;
				a <= cmd_addr;
			end
			else if (pend && cnt == k_slow)
			begin
				rsp_valid <= 1'h1;
				pend <= 1'h0;
				cnt <= 4'h0;
			end
			else if (cmd_valid && !pend && cnt == k_slow)
				cmd_ready <= 1'h1;
			else if (cmd_valid || pend)
				cnt <= cnt + 4'h1;
		end
	end
endmodule

// [tb/cmo_unit_bench.sv]
// self-checking bench of the cache maintenance operation unit
// assumes the array model answers every command it takes
module cmo_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, op_valid, hold_wr_en, k_hit, k_dirty, k_err;
	logic op_ready, op_done, op_error, cmd_valid, cmd_ready, cmd_broadcast;
	logic rsp_valid, rsp_hit, rsp_line_valid, rsp_dirty, rsp_err, err_seen;
	logic [31:0] instr, base_value, hold_wr_data, cmd_addr, last_addr;
	logic [31:0] tag_low_holding_reg, tag_high_holding_reg;
	logic [31:0] line_data_low_reg, line_data_high_reg;
	logic [31:0] rsp_tag_lo, rsp_tag_hi, rsp_dat_lo, rsp_dat_hi;
	logic [2:0] coherency_attribute, cmd_kind;
	logic [1:0] hold_wr_sel, cmd_level;
	logic [3:0] k_slow;
	logic [5:0] log_q[$]; // commands taken: broadcast, kind, level
	logic [5:0] none[$]; // stays empty
	int miscompares = 0;
	int cmp_count = 0;
	cmo_unit dut (.clk_sys, .rst_n, .op_valid, .instr, .base_value,
		.coherency_attribute, .op_ready, .op_done, .op_error, .hold_wr_en,
		.hold_wr_sel, .hold_wr_data, .tag_low_holding_reg,
		.tag_high_holding_reg, .line_data_low_reg, .line_data_high_reg,
		.cmd_valid, .cmd_ready, .cmd_kind, .cmd_level, .cmd_addr,
		.cmd_broadcast, .rsp_valid, .rsp_hit, .rsp_line_valid, .rsp_dirty,
		.rsp_err, .rsp_tag_lo, .rsp_tag_hi, .rsp_dat_lo, .rsp_dat_hi);
	cache_array_model arr (.clk_sys, .rst_n, .cmd_valid, .cmd_addr, .k_hit,
		.k_dirty, .k_err, .k_slow, .cmd_ready, .rsp_valid, .rsp_hit,
		.rsp_line_valid, .rsp_dirty, .rsp_err, .rsp_tag_lo, .rsp_tag_hi,
		.rsp_dat_lo, .rsp_dat_hi);
	// 200 MHz core clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// record every command the arrays take
	always @(posedge clk_sys)
	begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
		begin
			log_q.push_back({cmd_broadcast, cmd_kind, cmd_level});
			last_addr = cmd_addr;
		end
	end
	function automatic logic [5:0] e(logic b, logic [2:0] k, logic [1:0] l);
		return {b, k, l};
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_word(string n, logic [31:0] x, logic [31:0] g);
		cmp_count++;
		if (g !== x)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chk_seq(string n, logic [5:0] x[$]);
		chk_word(n, 32'(x.size()), 32'(log_q.size()));
		foreach (x[i])
			if (i < log_q.size())
				chk_word(n, {26'h0, x[i]}, {26'h0, log_q[i]});
	endtask
	// bounded wait at falling edges
	task automatic wait_for(ref logic s);
		for (int n = 0; n < 300 && s !== 1'b1; n++)
			@(negedge clk_sys);
		if (s !== 1'b1)
		begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic run_op(logic [2:0] op, logic [1:0] sel, logic [15:0] ofs,
		logic [31:0] base, logic [2:0] attr);
		wait_for(op_ready);
		log_q.delete();
		instr = {11'h0, op, sel, ofs};
		base_value = base;
		coherency_attribute = attr;
		op_valid = 1'b1;
		@(negedge clk_sys);
		op_valid = 1'b0;
		wait_for(op_done);
		err_seen = op_error;
	endtask
	// unbuilt codes and the optional code on every cache
	task automatic t_codes();
		for (int s = 0; s < 4; s++)
		begin
			run_op(cmo_pkg::OP_IMPL, 2'(s), 16'h0, 32'h40, 3'h0);
			chk_seq("impl", '{e(0, cmo_pkg::CMD_IMPL, 2'(s))});
			run_op(3'(6 + s / 2), 2'(s), 16'h0, 32'h40, 3'h4);
			chk_seq("nop", none);
		end
	endtask
	// index invalidate on write-back and write-through levels
	task automatic t_index();
		k_dirty = 1'b1;
		k_err = 1'b1;
		run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_D, 16'h0, 32'h100, 3'h4);
		chk_seq("idx d", '{e(0, cmo_pkg::CMD_PROBE_IDX, 1),
			e(0, cmo_pkg::CMD_WRITEBACK, 1), e(0, cmo_pkg::CMD_INVAL, 1)});
		chk_word("idx err", 32'h1, {31'h0, err_seen});
		k_dirty = 1'b0;
		k_err = 1'b0;
		run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_S, 16'h0, 32'h100, 3'h0);
		chk_seq("idx s", '{e(0, cmo_pkg::CMD_PROBE_IDX, 3),
			e(0, cmo_pkg::CMD_INVAL, 3)});
		run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_I, 16'h0, 32'h100, 3'h0);
		chk_seq("idx i", '{e(0, cmo_pkg::CMD_INVAL, 0)});
	endtask
	// holding registers loaded, tag written, then a tag and data read from another cache
	task automatic t_tag();
		logic [31:0] a;
		a = 32'h80000040;
		for (int i = 0; i < 4; i++)
		begin
			hold_wr_en = 1'b1;
			hold_wr_sel = 2'(i);
			hold_wr_data = 32'hc0de0000 + 32'(i);
			@(negedge clk_sys);
		end
		hold_wr_en = 1'b0;
		chk_word("tag lo", 32'hc0de0000, tag_low_holding_reg);
		chk_word("tag hi", 32'hc0de0001, tag_high_holding_reg);
		k_err = 1'b1;
		run_op(cmo_pkg::OP_ST_TAG, cmo_pkg::SEL_T, 16'h20, 32'h0, 3'h0);
		chk_seq("st", '{e(0, cmo_pkg::CMD_WRITE_TAG, 2)});
		chk_word("st err", 32'h0, {31'h0, err_seen});
		run_op(cmo_pkg::OP_LD_TAG, cmo_pkg::SEL_D, 16'h40, 32'h80000000, 3'h0);
		chk_seq("ld", '{e(0, cmo_pkg::CMD_READ_TAG, 1)});
		chk_word("ld err", 32'h0, {31'h0, err_seen});
		chk_word("ld tlo", a ^ 32'ha5a50000, tag_low_holding_reg);
		chk_word("ld thi", ~a, tag_high_holding_reg);
		chk_word("ld dlo", a + 32'h1, line_data_low_reg);
		chk_word("ld dhi", a + 32'h2, line_data_high_reg);
		k_err = 1'b0;
	endtask
	// hit operations: inner first, one broadcast choice, fill, address
	task automatic t_hit();
		{k_hit, k_dirty} = 2'h3;
		run_op(cmo_pkg::OP_HIT_INV, cmo_pkg::SEL_S, 16'h0, 32'h1000, 3'h4);
		chk_seq("hi s", '{e(1, cmo_pkg::CMD_PROBE_HIT, 1),
			e(1, cmo_pkg::CMD_INVAL, 1), e(1, cmo_pkg::CMD_PROBE_HIT, 3),
			e(1, cmo_pkg::CMD_INVAL, 3)});
		k_hit = 1'b0;
		run_op(cmo_pkg::OP_HIT_INV, cmo_pkg::SEL_T, 16'h0, 32'h1000, 3'h2);
		chk_seq("hi t", '{e(0, cmo_pkg::CMD_PROBE_HIT, 1),
			e(0, cmo_pkg::CMD_PROBE_HIT, 3),
			e(0, cmo_pkg::CMD_PROBE_HIT, 2)});
		run_op(cmo_pkg::OP_HIT_WBI, cmo_pkg::SEL_I, 16'h0, 32'h2000, 3'h0);
		chk_seq("fill", '{e(0, cmo_pkg::CMD_FILL, 0)});
		chk_word("fill a", 32'h2000, last_addr);
		k_hit = 1'b1;
		k_dirty = 1'b1;
		k_slow = 4'h3;
		run_op(cmo_pkg::OP_HIT_WBI, cmo_pkg::SEL_D, 16'hfff0, 32'h100, 3'h5);
		chk_seq("hwbi", '{e(1, cmo_pkg::CMD_PROBE_HIT, 1),
			e(1, cmo_pkg::CMD_WRITEBACK, 1),
			e(1, cmo_pkg::CMD_INVAL, 1)});
		chk_word("ea", 32'hf0, last_addr);
	endtask
	initial
	begin
		rst_n = 1'b0;
		op_valid = 1'b0;
		instr = 32'h0;
		base_value = 32'h0;
		coherency_attribute = 3'h0;
		hold_wr_en = 1'b0;
		hold_wr_sel = 2'h0;
		hold_wr_data = 32'h0;
		{k_hit, k_dirty, k_err, k_slow} = 7'h0;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		t_codes();
		t_index();
		t_tag();
		t_hit();
		end_of_test();
	end
endmodule
